// ==== shared/ppstat_pkg.sv ====
// Shared constants and types of the power path status register block.
//=====================================================================
// Behaviour
// - Forty-bit read-only status at 26h, resets zero.
// - Bits 39-38: 1h aux input, 2h VBUS.
// - Dead battery forces the VBUS source code.
// - Bit 34 shows cable-supply switch overcurrent.
// - Bit 28 shows five volt switch overcurrent.
// - Bits 14-12 give external path switch state.
// - Bits 8-6 give five volt switch state.
// - Bits 1-0 give cable-supply switch state.
//=====================================================================
package ppstat_pkg;
   localparam int          PPSTAT_WIDTH   = 40;
   localparam logic [7:0]  PPSTAT_INDEX   = 8'h26;
   localparam logic [7:0]  LO_WORD_ADDR   = 8'h98;
   localparam logic [7:0]  HI_WORD_ADDR   = 8'h9C;
   localparam logic [7:0]  IRQ_STAT_ADDR  = 8'hA0;
   localparam logic [7:0]  IRQ_MASK_ADDR  = 8'hA4;
   localparam logic [39:0] PPSTAT_RESET   = 40'h00_0000_0000;
   localparam int          SRC_LSB        = 38;
   localparam int          CABLE_OC_BIT   = 34;
   localparam int          FIVE_OC_BIT    = 28;
   localparam int          EXT_LSB        = 12;
   localparam int          FIVE_LSB       = 6;
   localparam int          CABLE_LSB      = 0;
   localparam logic [1:0]  SRC_AUX        = 2'h1;
   localparam logic [1:0]  SRC_VBUS       = 2'h2;
   localparam logic [2:0]  FIVE_MAX_CODE  = 3'h2;
   localparam logic [2:0]  EXT_MAX_CODE   = 3'h3;
   localparam logic [3:0]  IRQ_RESET      = 4'h0;
   typedef enum logic [1:0] {
      PPSTAT_IDLE = 2'b00,
      PPSTAT_ACK  = 2'b01
   } ppstat_bus_t;
endpackage

// ==== core/ppstat_sync.sv ====
// Two-flip-flop synchroniser for the switch status pins.
`timescale 1ns/10ps
module ppstat_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ppstat_sync_t;
   ppstat_sync_t st;
   ppstat_sync_t next_st;
   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
   assign q = st.s2;
endmodule

// ==== core/ppstat_field.sv ====
// Builds the forty-bit status word from synchronised switch levels.
`timescale 1ns/10ps
module ppstat_field (
   input  wire logic        on_aux,
   input  wire logic        dead_battery,
   input  wire logic        cable_oc,
   input  wire logic        five_oc,
   input  wire logic [2:0]  ext_state,
   input  wire logic [2:0]  five_state,
   input  wire logic [1:0]  cable_state,
   output logic      [39:0] word
);
   import ppstat_pkg::*;
   always_comb begin
      word = '0;
      // A dead battery leaves VBUS as the only possible supply.
      word[SRC_LSB +: 2] = (on_aux && !dead_battery) ? SRC_AUX : SRC_VBUS;
      word[CABLE_OC_BIT] = cable_oc;
      word[FIVE_OC_BIT] = five_oc;
      word[EXT_LSB +: 3] = (ext_state > EXT_MAX_CODE) ? 3'h0 : ext_state;
      // Undefined switch codes read as disabled rather than leaking noise.
      word[FIVE_LSB +: 3] = (five_state > FIVE_MAX_CODE) ? 3'h0 : five_state;
      word[CABLE_LSB +: 2] = cable_state;
   end
endmodule

// ==== core/ppstat_top.sv ====
// Power path status register with a classic Wishbone slave and interrupt.
`timescale 1ns/10ps
module ppstat_top (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq,
   input  wire logic        on_aux,
   input  wire logic        dead_battery,
   input  wire logic        cable_supply_overcurrent,
   input  wire logic        five_volt_switch_overcurrent,
   input  wire logic [2:0]  external_path_switch_state,
   input  wire logic [2:0]  five_volt_switch_state,
   input  wire logic [1:0]  cable_supply_switch_state
);
   import ppstat_pkg::*;

   //==================================================================
   // Pin synchronisation
   logic [11:0] pins_s;
   logic [39:0] live_word;
   ppstat_sync #(.W(12)) u_sync (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ce      (ce),
      .d       ({on_aux, dead_battery, cable_supply_overcurrent, five_volt_switch_overcurrent,
                 external_path_switch_state, five_volt_switch_state, cable_supply_switch_state}),
      .q       (pins_s)
   );
   ppstat_field u_field (
      .on_aux       (pins_s[11]),
      .dead_battery (pins_s[10]),
      .cable_oc     (pins_s[9]),
      .five_oc      (pins_s[8]),
      .ext_state    (pins_s[7:5]),
      .five_state   (pins_s[4:2]),
      .cable_state  (pins_s[1:0]),
      .word         (live_word)
   );

   //==================================================================
   // State
   typedef struct packed {
      logic [39:0] status;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic [31:0] rdata;
      logic        ack;
      logic        irq;
      logic        seen;
   } ppstat_state_t;
   ppstat_state_t st;
   ppstat_state_t next_st;

   function automatic logic [3:0] events_of(input logic [39:0] w);
      events_of = {w[CABLE_OC_BIT], w[FIVE_OC_BIT], w[EXT_LSB +: 3] == 3'h1, w[FIVE_LSB +: 3] == 3'h1};
   endfunction

   logic       req;
   logic [3:0] rise;
   logic [3:0] w1c;
   assign req  = wb_cyc_i && wb_stb_i && !st.ack;
   assign rise = events_of(live_word) & ~events_of(st.status) & {4{st.seen}};
   assign w1c  = (req && wb_we_i && wb_adr_i == IRQ_STAT_ADDR && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

   always_comb begin
      next_st        = st;
      next_st.status = live_word;
      next_st.seen   = 1'b1;
      next_st.ack    = req;
      // Set beats clear so an event in the clearing cycle survives.
      next_st.irq_stat = (st.irq_stat & ~w1c) | rise;
      if (req && wb_we_i && wb_adr_i == IRQ_MASK_ADDR && wb_sel_i[0]) begin
         next_st.irq_mask = wb_dat_i[3:0];
      end
      next_st.rdata = 32'h0000_0000;
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            LO_WORD_ADDR:  next_st.rdata = st.status[31:0];
            HI_WORD_ADDR:  next_st.rdata = {24'h00_0000, st.status[39:32]};
            IRQ_STAT_ADDR: next_st.rdata = {28'h000_0000, st.irq_stat};
            IRQ_MASK_ADDR: next_st.rdata = {28'h000_0000, st.irq_mask};
            default:       next_st.rdata = 32'h0000_0000;
         endcase
      end
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '{status: PPSTAT_RESET, irq_stat: IRQ_RESET, irq_mask: IRQ_RESET,
                 rdata: 32'h0000_0000, ack: 1'b0, irq: 1'b0, seen: 1'b0};
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign wb_dat_o = st.rdata;
   assign wb_ack_o = st.ack;
   assign irq      = st.irq;

   //==================================================================
   // Checks
   sequence read_lo_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == LO_WORD_ADDR && ce;
   endsequence
   sequence read_hi_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == HI_WORD_ADDR && ce;
   endsequence

   reset_zero_a: assert property (@(posedge clk_sys) $past(srst) |-> st.status == PPSTAT_RESET)
      else $error("status not zero after reset");
   low_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      read_lo_s |=> wb_ack_o && wb_dat_o == $past(st.status[31:0]))
      else $error("low word read mismatch");
   source_code_a: assert property (@(posedge clk_sys) disable iff (srst)
      st.status[SRC_LSB +: 2] == SRC_AUX || st.status[SRC_LSB +: 2] == SRC_VBUS || !st.seen)
      else $error("source field holds reserved code");
   dead_vbus_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce && $past(ce) && pins_s[10] |=> st.status[SRC_LSB +: 2] == SRC_VBUS)
      else $error("dead battery without VBUS code");
   cable_oc_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce |=> st.status[CABLE_OC_BIT] == $past(pins_s[9]))
      else $error("cable overcurrent bit wrong");
   five_oc_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce |=> st.status[FIVE_OC_BIT] == $past(pins_s[8]))
      else $error("five volt overcurrent bit wrong");
   ext_field_a: assert property (@(posedge clk_sys) disable iff (srst)
      st.status[EXT_LSB +: 3] <= EXT_MAX_CODE)
      else $error("external switch code out of range");
   five_field_a: assert property (@(posedge clk_sys) disable iff (srst)
      st.status[FIVE_LSB +: 3] <= FIVE_MAX_CODE)
      else $error("five volt switch code out of range");
   cable_field_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce |=> st.status[CABLE_LSB +: 2] == $past(pins_s[1:0]))
      else $error("cable switch field wrong");
   reserved_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
      read_hi_s |=> wb_dat_o[31:8] == 24'h00_0000 && wb_dat_o[5:3] == 3'h0 && wb_dat_o[1:0] == 2'h0)
      else $error("reserved bits not zero");
   low_reserved_a: assert property (@(posedge clk_sys) disable iff (srst)
      read_lo_s |=> wb_dat_o[31:29] == 3'h0 && wb_dat_o[27:15] == 13'h0000 && wb_dat_o[11:9] == 3'h0
                    && wb_dat_o[5:2] == 4'h0)
      else $error("reserved low bits not zero");
   ack_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   irq_level_a: assert property (@(posedge clk_sys) disable iff (srst)
      irq == |(st.irq_stat & st.irq_mask))
      else $error("interrupt level does not follow status and mask");
endmodule

// ==== tb/ppstat_tb_top.sv ====
// Self-checking bench of the power path status register block.
`timescale 1ns/10ps
module ppstat_tb_top;
   import ppstat_pkg::*;
   `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
      $display("unexpected %s exp=%h got=%h", nm, e, g); end end
   //==================================================================
   // Signals
   logic        clk_sys = 1'b0;
   logic        srst    = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, irq;
   logic        on_aux = 1'b0, dead_battery = 1'b0, c_oc = 1'b0, f_oc = 1'b0;
   logic [2:0]  ext_s = 3'h0, five_s = 3'h0;
   logic [1:0]  cab_s = 2'h0;
   logic [31:0] exp_q[$];
   int          num_errors = 0;
   int          n_compared = 0;
   always #12.5 clk_sys = ~clk_sys;
   ppstat_top i_dut (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq(irq), .on_aux(on_aux), .dead_battery(dead_battery),
      .cable_supply_overcurrent(c_oc), .five_volt_switch_overcurrent(f_oc),
      .external_path_switch_state(ext_s), .five_volt_switch_state(five_s), .cable_supply_switch_state(cab_s));
   //==================================================================
   // Tasks
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Entered just after an edge; the request stays put until ack is sampled.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      int n;
      n = 0;
      if (!w) exp_q.push_back(e);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) `CHK("ack_wait", 1'b1, wb_ack_o)
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask
   function automatic logic [39:0] exp_word();
      logic [39:0] w;
      w = 40'h0;
      w[39:38] = (on_aux && !dead_battery) ? SRC_AUX : SRC_VBUS;
      w[34] = c_oc;
      w[28] = f_oc;
      w[14:12] = (ext_s > EXT_MAX_CODE) ? 3'h0 : ext_s;
      w[8:6] = (five_s > FIVE_MAX_CODE) ? 3'h0 : five_s;
      w[1:0] = cab_s;
      return w;
   endfunction
   //==================================================================
   // Read data monitor
   always @(posedge clk_sys) begin
      logic [31:0] e;
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD_BEEF;
         `CHK("read_data", e, wb_dat_o)
      end
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      `CHK("watchdog", 1'b1, 1'b0)
      end_sim();
   end
   //==================================================================
   // Tests
   initial begin
      logic [39:0] w;
      void'($urandom(73672));
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      // With every pin low the source field already reads the VBUS code.
      w = exp_word();
      wb(1'b0, LO_WORD_ADDR, 32'h0, w[31:0]);
      wb(1'b0, HI_WORD_ADDR, 32'h0, {24'h0, w[39:32]});
      $display("test reset_values done");
      // Counting codes cover every switch encoding, random bits cover the flags.
      for (int i = 0; i < 8; i++) begin
         {on_aux, dead_battery, c_oc, f_oc} <= 4'($urandom);
         ext_s <= 3'(i);
         five_s <= 3'(i + 3);
         cab_s <= 2'(i);
         repeat (4) @(posedge clk_sys);
         w = exp_word();
         `CHK("irq_masked", 1'b0, irq)
         wb(1'b0, LO_WORD_ADDR, 32'h0, w[31:0]);
         wb(1'b0, HI_WORD_ADDR, 32'h0, {24'h0, w[39:32]});
         wb(1'b1, LO_WORD_ADDR, 32'($urandom), 32'h0);
         wb(1'b1, HI_WORD_ADDR, 32'hFFFF_FFFF, 32'h0);
         wb(1'b0, LO_WORD_ADDR, 32'h0, w[31:0]);
         wb(1'b0, HI_WORD_ADDR, 32'h0, {24'h0, w[39:32]});
      end
      wb(1'b0, 8'h50, 32'h0, 32'h0);
      $display("test field_codes done");
      c_oc <= 1'b0;
      repeat (4) @(posedge clk_sys);
      wb(1'b1, IRQ_STAT_ADDR, 32'h0000_000F, 32'h0);
      wb(1'b1, IRQ_MASK_ADDR, 32'h0000_0008, 32'h0);
      c_oc <= 1'b1;
      repeat (5) @(posedge clk_sys);
      `CHK("irq_raise", 1'b1, irq)
      wb(1'b0, IRQ_STAT_ADDR, 32'h0, 32'h0000_0008);
      wb(1'b1, IRQ_MASK_ADDR, 32'h0, 32'h0);
      repeat (2) @(posedge clk_sys);
      `CHK("irq_mask", 1'b0, irq)
      wb(1'b1, IRQ_MASK_ADDR, 32'h0000_0008, 32'h0);
      repeat (2) @(posedge clk_sys);
      `CHK("irq_unmask", 1'b1, irq)
      wb(1'b1, IRQ_STAT_ADDR, 32'h0000_0008, 32'h0);
      repeat (2) @(posedge clk_sys);
      `CHK("irq_clear", 1'b0, irq)
      $display("test interrupt done");
      end_sim();
   end
endmodule
